// ==== design/dod_top.sv ====
// options word holder with axi4-lite readback and pin steering
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Function
// - The upper sixteen bits of the options word are a user identifier readable by software.
// - Bit 15 set gives the bus power switch pin to the USB module, clear gives it to the port.
// - Bit 14 set gives the USB identity pin to the USB module, clear gives it to the port.
// - Bit 4 set puts two-wire one on port B lines 8/9, clear on port B line 5 and port C line 9.
// - Bit 3 set runs the secondary oscillator at normal power, clear at high power.
module dod_top (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// nonvolatile word source
	input wire logic [31:0] nv_options_word,
	input wire logic [31:0] nv_alt_options_word,
	input wire logic nv_use_alt,
	input wire logic nv_ready,
	// axi4-lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// usb module side
	input wire logic usb_bus_power_o,
	input wire logic usb_id_pull_o,
	input wire logic usb_id_pull_oe_n,
	// port logic side
	input wire dod_pkg::dod_pad_type port_bus_power,
	input wire dod_pkg::dod_pad_type port_usb_id,
	input wire dod_pkg::dod_pad_type port_b8,
	input wire dod_pkg::dod_pad_type port_b9,
	input wire dod_pkg::dod_pad_type port_b5,
	input wire dod_pkg::dod_pad_type port_c9,
	// two-wire one side
	input wire logic tw_data_oe_n,
	input wire logic tw_clock_oe_n,
	// pads
	output dod_pkg::dod_pad_type pad_bus_power_switch_pin,
	output dod_pkg::dod_pad_type pad_usb_identity_pin,
	output dod_pkg::dod_pad_type pad_port_b_line_eight,
	output dod_pkg::dod_pad_type pad_port_b_line_nine,
	output dod_pkg::dod_pad_type pad_port_b_line_five,
	output dod_pkg::dod_pad_type pad_port_c_line_nine,
	// static settings
	output logic [15:0] user_identifier,
	output logic secondary_osc_power_sel,
	output logic options_valid
);
	import dod_pkg::*;

	logic rst_meta_q;
	logic rst_sync_q;
	wire logic srst_n = rst_sync_q;

	// reset release through two flops
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// loader state
	dod_state_type state_q, state_d;
	logic [31:0] opt_q, opt_d;
	logic [31:0] alt_q, alt_d;
	logic alt_sel_q, alt_sel_d;
	logic reload_req_q, reload_req_d;
	logic wr_reload;

	// capture the word once per load; nothing else touches it
	always_comb
	begin
		state_d = state_q;
		opt_d = opt_q;
		alt_d = alt_q;
		alt_sel_d = alt_sel_q;
		reload_req_d = reload_req_q | wr_reload;
		unique case (state_q)
			ST_IDLE:
			begin
				state_d = ST_LOAD;
			end
			ST_LOAD:
			begin
				if (nv_ready)
				begin
					opt_d = nv_use_alt ? nv_alt_options_word : nv_options_word;
					alt_d = nv_alt_options_word;
					alt_sel_d = nv_use_alt;
					// a request landing in the capture cycle is kept: set wins
					reload_req_d = wr_reload;
					state_d = ST_DONE;
				end
			end
			ST_DONE:
			begin
				if (reload_req_q)
					state_d = ST_LOAD;
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge srst_n)
	begin
		if (!srst_n)
		begin
			state_q <= ST_IDLE;
			opt_q <= OPT_ERASED;
			alt_q <= OPT_ERASED;
			alt_sel_q <= 1'b0;
			reload_req_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			opt_q <= opt_d;
			alt_q <= alt_d;
			alt_sel_q <= alt_sel_d;
			reload_req_q <= reload_req_d;
		end
	end

	// decode and route; settings follow the held word only
	dod_settings_type settings;

	dod_decode u_decode (
		.word(opt_q),
		.settings(settings)
	);

	dod_pin_route u_route (
		.settings(settings),
		.usb_bus_power_o(usb_bus_power_o),
		.usb_id_pull_o(usb_id_pull_o),
		.usb_id_pull_oe_n(usb_id_pull_oe_n),
		.port_bus_power(port_bus_power),
		.port_usb_id(port_usb_id),
		.port_b8(port_b8),
		.port_b9(port_b9),
		.port_b5(port_b5),
		.port_c9(port_c9),
		.tw_data_oe_n(tw_data_oe_n),
		.tw_clock_oe_n(tw_clock_oe_n),
		.pad_bus_power_switch_pin(pad_bus_power_switch_pin),
		.pad_usb_identity_pin(pad_usb_identity_pin),
		.pad_port_b_line_eight(pad_port_b_line_eight),
		.pad_port_b_line_nine(pad_port_b_line_nine),
		.pad_port_b_line_five(pad_port_b_line_five),
		.pad_port_c_line_nine(pad_port_c_line_nine)
	);

	assign user_identifier = settings.user_identifier;
	assign secondary_osc_power_sel = settings.secondary_osc_power_sel;
	assign options_valid = (state_q == ST_DONE);

	// axi4-lite write side: address and data taken in either order
	logic aw_held_q, aw_held_d;
	logic w_held_q, w_held_d;
	logic [3:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic w_strb0_q, w_strb0_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic wr_fire;

	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready = !w_held_q && !bvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;

	always_comb
	begin
		aw_held_d = aw_held_q;
		w_held_d = w_held_q;
		aw_addr_d = aw_addr_q;
		w_data_d = w_data_q;
		w_strb0_d = w_strb0_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_d = 1'b1;
			aw_addr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_d = 1'b1;
			w_data_d = s_axi_wdata;
			w_strb0_d = s_axi_wstrb[0];
		end
		wr_fire = aw_held_q && w_held_q;
		if (wr_fire)
		begin
			aw_held_d = 1'b0;
			w_held_d = 1'b0;
			bvalid_d = 1'b1;
			// only the reload strobe is writable; the word itself is read only
			bresp_d = (aw_addr_q == ADDR_CONTROL) ? RESP_OKAY : RESP_SLVERR;
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
	end

	assign wr_reload = wr_fire && (aw_addr_q == ADDR_CONTROL) && w_strb0_q
		&& w_data_q[CTRL_RELOAD_BIT];

	always_ff @(posedge mclk or negedge srst_n)
	begin
		if (!srst_n)
		begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h00000000;
			w_strb0_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end
		else
		begin
			aw_held_q <= aw_held_d;
			w_held_q <= w_held_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb0_q <= w_strb0_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
		end
	end

	// axi4-lite read side, one cycle to answer
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;

	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_comb
	begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_OPTIONS: rdata_d = opt_q;
				ADDR_ALT_OPTIONS: rdata_d = alt_q;
				ADDR_STATUS: rdata_d = {29'h00000000, alt_sel_q,
					dod_rsv_ok(opt_q), options_valid};
				ADDR_CONTROL: rdata_d = 32'h00000000;
				default:
				begin
					rdata_d = 32'h00000000;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
	end

	always_ff @(posedge mclk or negedge srst_n)
	begin
		if (!srst_n)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end
		else
		begin
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end
endmodule // dod_top
`default_nettype wire

// ==== design/dod_pkg.sv ====
// package: options word layout, register map and shared carrier types
package dod_pkg;
	// options word field positions
	localparam int UID_HI = 31;
	localparam int UID_LO = 16;
	localparam int BUS_PWR_BIT = 15;
	localparam int USB_ID_BIT = 14;
	localparam int RSV_HI_HI = 13;
	localparam int RSV_HI_LO = 5;
	localparam int TWO_WIRE_BIT = 4;
	localparam int SECONDARY_OSCILLATOR_PWR_BIT = 3;
	localparam int RSV_LO_HI = 2;
	localparam int RSV_LO_LO = 0;
	// erased word: every bit one
	localparam logic [31:0] OPT_ERASED = 32'hFFFFFFFF;
	// reserved positions, all must be programmed as one
	localparam logic [31:0] RSV_MASK = 32'h00003FE7;
	// register byte addresses
	localparam logic [3:0] ADDR_OPTIONS = 4'h0;
	localparam logic [3:0] ADDR_ALT_OPTIONS = 4'h4;
	localparam logic [3:0] ADDR_STATUS = 4'h8;
	localparam logic [3:0] ADDR_CONTROL = 4'hC;
	// status and control fields
	localparam int STAT_VALID_BIT = 0;
	localparam int STAT_RSV_OK_BIT = 1;
	localparam int STAT_ALT_SEL_BIT = 2;
	localparam int CTRL_RELOAD_BIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// decoded static settings
	typedef struct packed {
		logic [15:0] user_identifier;
		logic bus_power_pin_owner_sel;
		logic usb_identity_pin_owner_sel;
		logic two_wire_alt_location_sel;
		logic secondary_osc_power_sel;
	} dod_settings_type;

	// pad drive pair for one pin
	typedef struct packed {
		logic o;
		logic oe_n;
	} dod_pad_type;

	// loader state
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOAD = 2'b01,
		ST_DONE = 2'b11
	} dod_state_type;

	// reserved-bit check used by the status path only
	function automatic logic dod_rsv_ok(input logic [31:0] w);
		dod_rsv_ok = ((w & RSV_MASK) == RSV_MASK);
	endfunction
endpackage

// ==== design/dod_decode.sv ====
// decode of the options word into static settings
`timescale 1ns/1ps
`default_nettype none
module dod_decode (
	// raw word
	input wire logic [31:0] word,
	// settings
	output dod_pkg::dod_settings_type settings
);
	import dod_pkg::*;

	// pure field extraction
	always_comb
	begin
		settings.user_identifier = word[UID_HI:UID_LO];
		settings.bus_power_pin_owner_sel = word[BUS_PWR_BIT];
		settings.usb_identity_pin_owner_sel = word[USB_ID_BIT];
		settings.two_wire_alt_location_sel = word[TWO_WIRE_BIT];
		settings.secondary_osc_power_sel = word[SECONDARY_OSCILLATOR_PWR_BIT];
	end
endmodule // dod_decode
`default_nettype wire

// ==== design/dod_pin_route.sv ====
// pin ownership and two-wire location steering
`timescale 1ns/1ps
`default_nettype none
module dod_pin_route (
	// settings
	input wire dod_pkg::dod_settings_type settings,
	// usb module side
	input wire logic usb_bus_power_o,
	input wire logic usb_id_pull_o,
	input wire logic usb_id_pull_oe_n,
	// general port side
	input wire dod_pkg::dod_pad_type port_bus_power,
	input wire dod_pkg::dod_pad_type port_usb_id,
	input wire dod_pkg::dod_pad_type port_b8,
	input wire dod_pkg::dod_pad_type port_b9,
	input wire dod_pkg::dod_pad_type port_b5,
	input wire dod_pkg::dod_pad_type port_c9,
	// two-wire one module side, open drain
	input wire logic tw_data_oe_n,
	input wire logic tw_clock_oe_n,
	// pads
	output dod_pkg::dod_pad_type pad_bus_power_switch_pin,
	output dod_pkg::dod_pad_type pad_usb_identity_pin,
	output dod_pkg::dod_pad_type pad_port_b_line_eight,
	output dod_pkg::dod_pad_type pad_port_b_line_nine,
	output dod_pkg::dod_pad_type pad_port_b_line_five,
	output dod_pkg::dod_pad_type pad_port_c_line_nine
);
	import dod_pkg::*;

	logic primary;
	dod_pad_type tw_data;
	dod_pad_type tw_clock;

	// open drain: drive low only, enable low while pulling
	assign tw_data = '{o: 1'b0, oe_n: tw_data_oe_n};
	assign tw_clock = '{o: 1'b0, oe_n: tw_clock_oe_n};
	assign primary = settings.two_wire_alt_location_sel;

	// ownership muxes
	always_comb
	begin
		pad_bus_power_switch_pin = settings.bus_power_pin_owner_sel ?
			'{o: usb_bus_power_o, oe_n: 1'b0} : port_bus_power;
		pad_usb_identity_pin = settings.usb_identity_pin_owner_sel ?
			'{o: usb_id_pull_o, oe_n: usb_id_pull_oe_n} : port_usb_id;
		// unused location falls back to the port logic
		pad_port_b_line_eight = primary ? tw_data : port_b8;
		pad_port_b_line_nine = primary ? tw_clock : port_b9;
		pad_port_b_line_five = primary ? port_b5 : tw_data;
		pad_port_c_line_nine = primary ? port_c9 : tw_clock;
	end
endmodule // dod_pin_route
`default_nettype wire

// ==== tb/dod_chk.sv ====
// checker: port-level assertions for the option decoder top
`timescale 1ns/1ps
`default_nettype none
module dod_chk (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// word source and pin drivers
	input wire logic nv_ready,
	input wire logic usb_bus_power_o,
	input wire logic usb_id_pull_o,
	input wire logic usb_id_pull_oe_n,
	input wire logic tw_data_oe_n,
	input wire logic tw_clock_oe_n,
	// register bus
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	// pads and settings
	input wire dod_pkg::dod_pad_type pad_bus_power_switch_pin,
	input wire dod_pkg::dod_pad_type pad_usb_identity_pin,
	input wire dod_pkg::dod_pad_type pad_port_b_line_eight,
	input wire dod_pkg::dod_pad_type pad_port_b_line_nine,
	input wire logic [15:0] user_identifier,
	input wire logic secondary_osc_power_sel,
	input wire logic options_valid
);
	import dod_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// loaded from the first capture on; options_valid drops again while a reload runs
	logic loaded_q;
	logic loaded_d;
	always_comb
	begin
		loaded_d = loaded_q | options_valid;
	end
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			loaded_q <= 1'b0;
		else
			loaded_q <= loaded_d;
	end
	// read handshake, answer expected one cycle later
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// reset over and nothing captured yet, so the erased word is in force
	sequence s_unloaded;
		!loaded_q && !options_valid;
	endsequence
	// before any load the erased word gives both usb pins to the usb side
	a_bus_pwr_usb: assert property (s_unloaded |->
		pad_bus_power_switch_pin == {usb_bus_power_o, 1'b0})
		else $error("bus power pad not usb driven before load");
	a_id_pin_usb: assert property (s_unloaded |->
		pad_usb_identity_pin == {usb_id_pull_o, usb_id_pull_oe_n})
		else $error("identity pad not usb driven before load");
	a_tw_primary: assert property (s_unloaded |->
		pad_port_b_line_eight == {1'b0, tw_data_oe_n}
		&& pad_port_b_line_nine == {1'b0, tw_clock_oe_n})
		else $error("two-wire lines not on primary pins before load");
	a_erased_fields: assert property (s_unloaded |->
		user_identifier == 16'hFFFF && secondary_osc_power_sel)
		else $error("settings not erased before load");
	// a capture needs nv_ready at its edge, so no change without it
	a_settings_hold: assert property (!$past(nv_ready) |->
		$stable(user_identifier) && $stable(secondary_osc_power_sel))
		else $error("settings moved without a load");
	a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before ready");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before ready");
endmodule // dod_chk
bind dod_top dod_chk i_chk (.mclk, .rst_n, .nv_ready, .usb_bus_power_o, .usb_id_pull_o,
	.usb_id_pull_oe_n, .tw_data_oe_n, .tw_clock_oe_n, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.s_axi_rready, .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .pad_bus_power_switch_pin,
	.pad_usb_identity_pin, .pad_port_b_line_eight, .pad_port_b_line_nine, .user_identifier,
	.secondary_osc_power_sel, .options_valid);
`default_nettype wire

// ==== tb/testbench.sv ====
// testbench: option decoder regression
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dod_pkg::*;
	logic mclk, rst_n, nv_use_alt, nv_ready, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, options_valid, secondary_osc_power_sel;
	logic [31:0] nv_options_word, nv_alt_options_word, s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [15:0] user_identifier;
	logic [16:0] pat = '0;
	dod_pad_type pad_bus_power_switch_pin, pad_usb_identity_pin, pad_port_b_line_eight;
	dod_pad_type pad_port_b_line_nine, pad_port_b_line_five, pad_port_c_line_nine;
	int err_count, n_checks, n;
	logic [31:0] rw [5] = '{32'hA5C3FFFF, 32'h12343FE7, 32'h0001BFEF, 32'hFFFE7FF7, 32'h5A5A0000};
	logic ra [5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

	dod_top i_dut (.mclk, .rst_n, .nv_options_word, .nv_alt_options_word, .nv_use_alt, .nv_ready,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.usb_bus_power_o(pat[0]), .usb_id_pull_o(pat[2]), .usb_id_pull_oe_n(pat[1]),
		.port_bus_power(pat[4:3]), .port_usb_id(pat[6:5]), .port_b8(pat[8:7]), .port_b9(pat[10:9]),
		.port_b5(pat[12:11]), .port_c9(pat[14:13]), .tw_data_oe_n(pat[15]), .tw_clock_oe_n(pat[16]),
		.pad_bus_power_switch_pin, .pad_usb_identity_pin, .pad_port_b_line_eight,
		.pad_port_b_line_nine, .pad_port_b_line_five, .pad_port_c_line_nine, .user_identifier,
		.secondary_osc_power_sel, .options_valid);

	// clock
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// pin drivers wander every cycle so a stuck steering path shows
	always @(posedge mclk) pat <= pat + 17'h0B6D3;

	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic timeout();
		err_count++;
		$display("[ERR] bus wait expected answer seen none");
		results();
	endtask
	// one axi4-lite transfer; ready rises only once valid is seen, so the hold rules get exercised
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
		logic pa, pw, ta, tw, rdy, done;
		pa = 1'b1;
		pw = wr;
		done = 1'b0;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_arvalid <= !wr;
		// answer is taken at the edge where valid and ready are both high
		for (n = 0; !done; n++)
		begin
			if (n > 40) timeout();
			@(negedge mclk);
			ta = pa & (wr ? s_axi_awready : s_axi_arready);
			tw = pw & s_axi_wready;
			rdy = wr ? s_axi_bvalid : s_axi_rvalid;
			done = rdy & (wr ? s_axi_bready : s_axi_rready);
			rs = wr ? s_axi_bresp : s_axi_rresp;
			rd = s_axi_rdata;
			@(posedge mclk);
			pa = pa & !ta;
			pw = pw & !tw;
			s_axi_awvalid <= wr & pa;
			s_axi_arvalid <= !wr & pa;
			s_axi_wvalid <= pw;
			s_axi_bready <= wr & rdy & !done;
			s_axi_rready <= !wr & rdy & !done;
		end
	endtask
	// pad steering for a given effective word
	task automatic pads(input logic [31:0] w);
		@(negedge mclk);
		chk("bus pad", pad_bus_power_switch_pin, w[15] ? {pat[0], 1'b0} : pat[4:3]);
		chk("id pad", pad_usb_identity_pin, w[14] ? pat[2:1] : pat[6:5]);
		chk("b8 pad", pad_port_b_line_eight, w[4] ? {1'b0, pat[15]} : pat[8:7]);
		chk("b9 pad", pad_port_b_line_nine, w[4] ? {1'b0, pat[16]} : pat[10:9]);
		chk("b5 pad", pad_port_b_line_five, w[4] ? pat[12:11] : {1'b0, pat[15]});
		chk("c9 pad", pad_port_c_line_nine, w[4] ? pat[14:13] : {1'b0, pat[16]});
	endtask

	initial
	begin
		{rst_n, nv_ready, nv_use_alt, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
		{s_axi_wdata, err_count, n_checks} = '0;
		s_axi_wstrb = 4'hF;
		nv_options_word = rw[0];
		nv_alt_options_word = ~rw[0];
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		pads(32'hFFFFFFFF);
		chk("uid erased", user_identifier, 16'hFFFF);
		chk("osc erased", secondary_osc_power_sel, 1'b1);
		chk("valid pre", options_valid, 1'b0);
		$display("test reset done");
		// table: each row reloaded through the control register
		for (int i = 0; i < 5; i++)
		begin
			@(posedge mclk);
			nv_ready <= 1'b1;
			nv_options_word <= ra[i] ? ~rw[i] : rw[i];
			nv_alt_options_word <= ra[i] ? rw[i] : ~rw[i];
			nv_use_alt <= ra[i];
			xfer(1'b1, ADDR_CONTROL, 32'h1);
			chk("ctl resp", rs, RESP_OKAY);
			@(negedge mclk);
			for (n = 0; user_identifier !== rw[i][31:16]; n++)
			begin
				if (n > 20) timeout();
				@(negedge mclk);
			end
			chk("osc", secondary_osc_power_sel, rw[i][3]);
			pads(rw[i]);
			xfer(1'b0, ADDR_OPTIONS, 32'h0);
			chk("word rd", rd, rw[i]);
			xfer(1'b0, ADDR_STATUS, 32'h0);
			chk("status", rd[2:0], {ra[i], (rw[i] & RSV_MASK) == RSV_MASK, 1'b1});
			$display("test row %0d done", i);
		end
		// source word moves with no reload; a write to the read-only word is refused
		@(posedge mclk);
		nv_options_word <= 32'h0;
		nv_alt_options_word <= 32'h0;
		repeat (8) @(negedge mclk);
		chk("uid held", user_identifier, rw[4][31:16]);
		chk("osc held", secondary_osc_power_sel, rw[4][3]);
		xfer(1'b1, ADDR_OPTIONS, 32'h0);
		chk("ro resp", rs, RESP_SLVERR);
		xfer(1'b0, ADDR_OPTIONS, 32'h0);
		chk("ro word", rd, rw[4]);
		chk("word resp", rs, RESP_OKAY);
		xfer(1'b0, ADDR_ALT_OPTIONS, 32'h0);
		chk("alt word", rd, rw[4]);
		xfer(1'b0, 4'h2, 32'h0);
		chk("unmapped resp", rs, RESP_SLVERR);
		chk("unmapped data", rd, 32'h00000000);
		$display("test hold done");
		// second reset in mid-run returns the erased settings
		@(posedge mclk);
		rst_n <= 1'b0;
		pads(32'hFFFFFFFF);
		chk("uid reset", user_identifier, 16'hFFFF);
		chk("valid reset", options_valid, 1'b0);
		$display("test second reset done");
		// release again: the zeroed source words load as soon as the loader runs
		@(posedge mclk);
		rst_n <= 1'b1;
		for (n = 0; options_valid !== 1'b1; n++)
		begin
			if (n > 20) timeout();
			@(negedge mclk);
		end
		chk("uid reload", user_identifier, 16'h0000);
		chk("osc reload", secondary_osc_power_sel, 1'b0);
		pads(32'h00000000);
		xfer(1'b0, ADDR_STATUS, 32'h0);
		chk("status reload", rd[2:0], {1'b1, 1'b0, 1'b1});
		$display("test reload after reset done");
		results();
	end
endmodule // testbench
`default_nettype wire
